//--- rtl/dosm_pkg.sv
// constants, types and state layout of the output slot map
// ==========================================================================
package dosm_pkg;
  localparam int CH_N = 8;
  // function codes
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_DISC  = 8'h02;
  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL  = 8'h05;
  localparam logic [7:0] FC_WR_REG   = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS  = 8'h10;
  // exception codes
  localparam logic [7:0] EXC_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ADDR  = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  // area bases: zero-based form, conventional form
  localparam logic [15:0] DI_ALLOC_DA = 16'h0000;
  localparam logic [15:0] DI_ALLOC_MC = 16'h2711;
  localparam logic [15:0] DI_SLOT_DA  = 16'h0400;
  localparam logic [15:0] DI_SLOT_MC  = 16'h32C9;
  localparam logic [15:0] ST_BIT_DA   = 16'h0800;
  localparam logic [15:0] ST_BIT_MC   = 16'h36B1;
  localparam logic [15:0] IR_STAT_DA  = 16'h0300;
  localparam logic [15:0] IR_STAT_MC  = 16'h8980;
  localparam logic [15:0] IR_KIND_DA  = 16'h0400;
  localparam logic [15:0] IR_KIND_MC  = 16'h89E4;
  localparam logic [15:0] HR_IN_DA    = 16'h0400;
  localparam logic [15:0] HR_IN_MC    = 16'hB3B1;
  localparam logic [15:0] HR_OUT_DA   = 16'h0500;
  localparam logic [15:0] HR_OUT_MC   = 16'hB415;
  localparam logic [15:0] CO_ALLOC_DA = 16'h0000;
  localparam logic [15:0] CO_ALLOC_MC = 16'h0001;
  localparam logic [15:0] CO_SLOT_DA  = 16'h0400;
  localparam logic [15:0] CO_SLOT_MC  = 16'h0BB9;
  localparam logic [15:0] BITS_SLOT   = 16'h0008;
  localparam logic [15:0] IO_BITS     = 16'h0010;
  localparam logic [15:0] ST_BITS     = 16'h0008;
  localparam logic [15:0] ONE_WORD    = 16'h0001;
  localparam logic [15:0] COIL_ON     = 16'hFF00;
  localparam logic [15:0] COIL_OFF    = 16'h0000;
  // status word layout
  localparam int ST_WD_OFF  = 8;
  localparam int ST_FAULT   = 9;
  localparam int ST_INVALID = 10;
  localparam int ST_LFD_EN  = 11;
  // watchdog
  localparam logic [1:0] FAIL_LIMIT = 2'h3;
  localparam longint WDOG_MS  = 500;
  localparam longint CLK_HZ   = 200_000_000;
  localparam longint WDOG_CYC = WDOG_MS * CLK_HZ / 1000;
  localparam int     TMR_W    = 32;

  typedef enum logic [2:0] {
    WD_RUN   = 3'b001,
    WD_ARMED = 3'b010,
    WD_OFF   = 3'b100
  } dosm_wd_t;

  typedef struct packed {
    logic [7:0]  fc;
    logic [15:0] addr;
    logic        conv;
    logic [15:0] wdata;
  } dosm_req_t;

  typedef struct packed {
    logic        valid;
    logic        exc;
    logic [7:0]  code;
    logic [15:0] data;
  } dosm_rsp_t;

  typedef struct packed {
    logic [15:0]      out_bytes;
    logic [CH_N-1:0]  ch_out;
    logic [CH_N-1:0]  lf_s1;
    logic [CH_N-1:0]  lf_s2;
    logic [1:0]       fails;
    dosm_wd_t         wd;
    logic [TMR_W-1:0] tmr;
    dosm_rsp_t        rsp;
  } dosm_state_t;
endpackage : dosm_pkg

//--- rtl/dosm_slot_map.sv
// request decoder, output byte store, line fault and watchdog of one slot
module dosm_slot_map #(
  parameter int          SLOT       = 1,
  parameter int          ALLOC_BIT  = 0,
  parameter int          ALLOC_WORD = 0,
  parameter logic [15:0] KIND_CODE  = 16'h00A5, // arbitrary value
  parameter longint      WDOG_CYCLES = dosm_pkg::WDOG_CYC
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // master requests and answers
  input  wire logic                 req_valid_i,
  input  wire dosm_pkg::dosm_req_t  req_i,
  output dosm_pkg::dosm_rsp_t       rsp_o,
  // communication unit supervision
  input  wire logic                 comm_fail_i,
  input  wire logic                 comm_ok_i,
  input  wire logic                 lfd_enable_i,
  input  wire logic [7:0]           subst_value_i,
  // field side
  input  wire logic [7:0]           line_fault_i,
  output logic      [7:0]           ch_out_o,
  output logic                      wd_off_o
);
  // ========================================================================
  // parameter checks
  if (SLOT < 0 || SLOT > 200 || ALLOC_BIT < 0 || ALLOC_BIT > 4000 ||
      ALLOC_WORD < 0 || ALLOC_WORD > 200)
    $error("address parameters out of range");
  if (WDOG_CYCLES < 1 || WDOG_CYCLES > 64'hFFFF_FFFF)
    $error("WDOG_CYCLES does not fit the timer");

  localparam logic [15:0] SLOT_OFF  = 16'(8 * SLOT);
  localparam logic [15:0] SLOT_WORD = 16'(SLOT);
  localparam logic [15:0] ABIT      = 16'(ALLOC_BIT);
  localparam logic [15:0] AWORD     = 16'(ALLOC_WORD);
  localparam logic [dosm_pkg::TMR_W-1:0] WD_LAST =
    dosm_pkg::TMR_W'(WDOG_CYCLES - 1);

  // offset into an area, in whichever address form the master used
  function automatic logic [15:0] area_off(input logic [15:0] a,
      input logic cv, input logic [15:0] da, input logic [15:0] mc,
      input logic [15:0] sub);
    area_off = a - (cv ? mc : da) - sub;
  endfunction

  dosm_pkg::dosm_state_t s_r, s_nxt;
  logic [15:0] in_word;
  logic [15:0] status_word;
  logic [15:0] o_dia, o_dis, o_stb, o_irs, o_irk, o_hri, o_hro;
  logic [15:0] o_coa, o_cos;

  // ========================================================================
  // readback byte pair and status word
  genvar g;
  for (g = 0; g < dosm_pkg::CH_N; g++) begin : g_rb
    assign in_word[2*g]   = s_r.ch_out[g];
    assign in_word[2*g+1] = lfd_enable_i & s_r.lf_s2[g];
  end

  always_comb begin
    status_word = '0;
    status_word[dosm_pkg::ST_WD_OFF]  = (s_r.wd == dosm_pkg::WD_OFF);
    status_word[dosm_pkg::ST_FAULT]   = lfd_enable_i & (|s_r.lf_s2);
    status_word[dosm_pkg::ST_INVALID] = |(s_r.out_bytes &
                                          16'hAAAA);
    status_word[dosm_pkg::ST_LFD_EN]  = lfd_enable_i;
  end

  // ========================================================================
  // area offsets
  assign o_dia = area_off(req_i.addr, req_i.conv, dosm_pkg::DI_ALLOC_DA,
                          dosm_pkg::DI_ALLOC_MC, ABIT);
  assign o_dis = area_off(req_i.addr, req_i.conv, dosm_pkg::DI_SLOT_DA,
                          dosm_pkg::DI_SLOT_MC, SLOT_OFF);
  assign o_stb = area_off(req_i.addr, req_i.conv, dosm_pkg::ST_BIT_DA,
                          dosm_pkg::ST_BIT_MC, SLOT_OFF);
  assign o_irs = area_off(req_i.addr, req_i.conv, dosm_pkg::IR_STAT_DA,
                          dosm_pkg::IR_STAT_MC, SLOT_WORD);
  assign o_irk = area_off(req_i.addr, req_i.conv, dosm_pkg::IR_KIND_DA,
                          dosm_pkg::IR_KIND_MC, SLOT_WORD);
  assign o_hri = area_off(req_i.addr, req_i.conv, dosm_pkg::HR_IN_DA,
                          dosm_pkg::HR_IN_MC, AWORD);
  assign o_hro = area_off(req_i.addr, req_i.conv, dosm_pkg::HR_OUT_DA,
                          dosm_pkg::HR_OUT_MC, AWORD);
  assign o_coa = area_off(req_i.addr, req_i.conv, dosm_pkg::CO_ALLOC_DA,
                          dosm_pkg::CO_ALLOC_MC, ABIT);
  assign o_cos = area_off(req_i.addr, req_i.conv, dosm_pkg::CO_SLOT_DA,
                          dosm_pkg::CO_SLOT_MC, SLOT_OFF);

  // ========================================================================
  // next state
  always_comb begin
    logic [15:0] coff;
    logic        chit;
    logic        bitv;
    coff = '0;
    chit = 1'b0;
    bitv = 1'b0;
    s_nxt = s_r;
    s_nxt.lf_s1 = line_fault_i;
    s_nxt.lf_s2 = s_r.lf_s1;
    s_nxt.rsp   = '0;
    if (req_valid_i) begin
      s_nxt.rsp.valid = 1'b1;
      s_nxt.rsp.exc   = 1'b1;
      s_nxt.rsp.code  = dosm_pkg::EXC_ADDR;
      case (req_i.fc)
        dosm_pkg::FC_RD_DISC: begin
          if (o_dia < dosm_pkg::IO_BITS) begin
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc, {15'h0000, in_word[o_dia[3:0]]}};
          end else if (o_dis < dosm_pkg::IO_BITS) begin
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc, {15'h0000, in_word[o_dis[3:0]]}};
          end else if (o_stb < dosm_pkg::ST_BITS) begin
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc,
                          {15'h0000, status_word[{1'b1, o_stb[2:0]}]}};
          end
        end
        dosm_pkg::FC_RD_INREG: begin
          if (o_irs == 16'h0000) begin
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc, status_word};
          end else if (o_irk == 16'h0000) begin
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc, KIND_CODE};
          end
        end
        dosm_pkg::FC_RD_HOLD: begin
          if (o_hri < dosm_pkg::ONE_WORD) begin
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc, in_word};
          end else if (o_hro < dosm_pkg::ONE_WORD) begin
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc, s_r.out_bytes};
          end
        end
        dosm_pkg::FC_WR_REG, dosm_pkg::FC_WR_REGS: begin
          if (o_hro < dosm_pkg::ONE_WORD) begin
            s_nxt.out_bytes = req_i.wdata;
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc, req_i.wdata};
          end
        end
        dosm_pkg::FC_RD_COILS, dosm_pkg::FC_WR_COIL,
        dosm_pkg::FC_WR_COILS: begin
          chit = (o_coa < dosm_pkg::IO_BITS) || (o_cos < dosm_pkg::IO_BITS);
          coff = (o_coa < dosm_pkg::IO_BITS) ? o_coa : o_cos;
          bitv = (req_i.fc == dosm_pkg::FC_WR_COIL) ?
                 (req_i.wdata == dosm_pkg::COIL_ON) : req_i.wdata[0];
          if (chit && req_i.fc == dosm_pkg::FC_RD_COILS) begin
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc,
                          {15'h0000, s_r.out_bytes[coff[3:0]]}};
          end else if (chit && req_i.fc == dosm_pkg::FC_WR_COIL &&
                       req_i.wdata != dosm_pkg::COIL_ON &&
                       req_i.wdata != dosm_pkg::COIL_OFF) begin
            s_nxt.rsp.code = dosm_pkg::EXC_VALUE;
          end else if (chit) begin
            s_nxt.out_bytes[coff[3:0]] = bitv;
            s_nxt.rsp = '{1'b1, 1'b0, req_i.fc, req_i.wdata};
          end
        end
        default: s_nxt.rsp.code = dosm_pkg::EXC_FUNC;
      endcase
    end
    // watchdog: a good exchange wins over a failed one in the same cycle
    case (s_r.wd)
      dosm_pkg::WD_RUN: begin
        if (comm_ok_i) begin
          s_nxt.fails = '0;
        end else if (comm_fail_i) begin
          s_nxt.fails = s_r.fails + 2'h1;
          if (s_r.fails + 2'h1 == dosm_pkg::FAIL_LIMIT) begin
            s_nxt.wd  = dosm_pkg::WD_ARMED;
            s_nxt.tmr = '0;
          end
        end
      end
      dosm_pkg::WD_ARMED: begin
        s_nxt.tmr = s_r.tmr + 1'b1;
        if (s_r.tmr == WD_LAST) begin
          s_nxt.wd = dosm_pkg::WD_OFF;
        end
      end
      dosm_pkg::WD_OFF: begin
        if (comm_ok_i) begin
          s_nxt.wd    = dosm_pkg::WD_RUN;
          s_nxt.fails = '0;
        end
      end
      default: s_nxt.wd = dosm_pkg::WD_RUN;
    endcase
    // channel drive: invalid picks the substitute, watchdog forces off
    for (int i = 0; i < dosm_pkg::CH_N; i++) begin
      s_nxt.ch_out[i] = s_r.out_bytes[2*i+1] ? subst_value_i[i]
                                             : s_r.out_bytes[2*i];
    end
    if (s_r.wd == dosm_pkg::WD_OFF) s_nxt.ch_out = '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r    <= '0;
      s_r.wd <= dosm_pkg::WD_RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rsp_o    = s_r.rsp;
  assign ch_out_o = s_r.ch_out;
  assign wd_off_o = (s_r.wd == dosm_pkg::WD_OFF);

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  answer_one_cycle_a: assert property (req_valid_i |=> rsp_o.valid)
    else $error("request without answer");
  bad_func_a: assert property (req_valid_i && req_i.fc == 8'h07 |=>
    rsp_o.exc && rsp_o.code == dosm_pkg::EXC_FUNC)
    else $error("unknown code not refused");
  status_word_a: assert property (req_valid_i &&
    req_i.fc == dosm_pkg::FC_RD_INREG && !req_i.conv &&
    req_i.addr == dosm_pkg::IR_STAT_DA + SLOT_WORD |=> !rsp_o.exc)
    else $error("status word not served");
  conv_form_a: assert property (req_valid_i &&
    req_i.fc == dosm_pkg::FC_RD_DISC && req_i.conv &&
    req_i.addr == dosm_pkg::DI_ALLOC_MC + ABIT |=>
    rsp_o.data[0] == $past(in_word[0]))
    else $error("conventional input bit wrong");
  fault_mask_a: assert property (req_valid_i && !lfd_enable_i &&
    req_i.fc == dosm_pkg::FC_RD_INREG && req_i.addr == SLOT_WORD +
    (req_i.conv ? dosm_pkg::IR_STAT_MC : dosm_pkg::IR_STAT_DA) |=>
    !rsp_o.data[dosm_pkg::ST_FAULT])
    else $error("fault shown while disabled");
  reg_write_a: assert property (req_valid_i &&
    req_i.fc == dosm_pkg::FC_WR_REG && !req_i.conv &&
    req_i.addr == dosm_pkg::HR_OUT_DA + AWORD |=>
    s_r.out_bytes == $past(req_i.wdata))
    else $error("output word not stored");
  third_fail_a: assert property (s_r.wd == dosm_pkg::WD_RUN &&
    s_r.fails == 2'h2 && comm_fail_i && !comm_ok_i |=>
    s_r.wd == dosm_pkg::WD_ARMED && s_r.tmr == '0)
    else $error("third failure not armed");
  wd_off_a: assert property (wd_off_o |=> ch_out_o == 8'h00)
    else $error("outputs on after watchdog");
  subst_a: assert property (!wd_off_o && s_r.out_bytes[1] |=>
    ch_out_o[0] == $past(subst_value_i[0]))
    else $error("substitute value not driven");
  readback_a: assert property (req_valid_i &&
    req_i.fc == dosm_pkg::FC_RD_HOLD && !req_i.conv &&
    req_i.addr == dosm_pkg::HR_IN_DA + AWORD |=>
    rsp_o.data[0] == $past(ch_out_o[0]))
    else $error("readback state wrong");

  armed_c: cover property (s_r.wd == dosm_pkg::WD_ARMED);
  off_c: cover property (wd_off_o);
  coil_wr_c: cover property (req_valid_i &&
    req_i.fc == dosm_pkg::FC_WR_COILS ##1
    !rsp_o.exc);
  addr_exc_c: cover property (rsp_o.exc &&
    rsp_o.code == dosm_pkg::EXC_ADDR);
endmodule : dosm_slot_map

//--- tb/dosm_master.sv
// request-side model of the bus master facing the slot map
module dosm_master (
  // clock
  input  wire logic           clk_i,
  // requests towards the slot map
  output logic                req_valid_o,
  output dosm_pkg::dosm_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end

  // ==========================================================================
  // one request per call
  // gap adds idle cycles; even at 0 one idle cycle separates two requests
  task automatic send(input dosm_pkg::dosm_req_t r, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_o <= r;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    // released fields must not keep looking like the last request
    req_o <= ~r;
  endtask
endmodule // dosm_master

//--- tb/tb.sv
// self-checking bench of the output slot map
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("BAD %s exp %h got %h", nm, e, g); miscompares++; end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOT = 1;
  localparam int WD = 20;
  localparam logic [15:0] KIND = 16'h00A5; // arbitrary value
  typedef struct packed {
    dosm_pkg::dosm_rsp_t r;
    logic [15:0]         m;
  } dosm_note_t;
  logic                clk_i, rst_i, req_valid_i, comm_fail_i, comm_ok_i;
  logic                lfd_enable_i, wd_off_o, cv, wdo, b;
  logic [7:0]          subst_value_i, line_fault_i, ch_out_o;
  logic [15:0]         ow, w, st;
  dosm_pkg::dosm_req_t req_i;
  dosm_pkg::dosm_rsp_t rsp_o;
  dosm_note_t          notes[$];
  dosm_note_t          nt;
  int                  miscompares, n_compared, n, k;
  integer              seed;

  dosm_master u_dosm_master (.clk_i(clk_i), .req_valid_o(req_valid_i),
    .req_o(req_i));
  dosm_slot_map #(.SLOT(SLOT), .KIND_CODE(KIND), .WDOG_CYCLES(WD))
  u_dosm_slot_map (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .rsp_o(rsp_o), .comm_fail_i(comm_fail_i),
    .comm_ok_i(comm_ok_i), .lfd_enable_i(lfd_enable_i),
    .subst_value_i(subst_value_i), .line_fault_i(line_fault_i),
    .ch_out_o(ch_out_o), .wd_off_o(wd_off_o));

  // ==========================================================================
  // reference model
  function automatic logic [7:0] chm();
    for (int i = 0; i < 8; i++) begin
      chm[i] = !wdo && (ow[2*i+1] ? subst_value_i[i] : ow[2*i]);
    end
  endfunction
  function automatic logic [15:0] rbm();
    logic [7:0] c;
    c = chm();
    for (int i = 0; i < 8; i++) begin
      rbm[2*i] = c[i];
      rbm[2*i+1] = lfd_enable_i & line_fault_i[i];
    end
  endfunction
  function automatic logic [15:0] stm();
    return {4'h0, lfd_enable_i, |(ow & 16'hAAAA),
      |(line_fault_i & {8{lfd_enable_i}}), wdo, 8'h00};
  endfunction
  function automatic logic [15:0] ad(logic [15:0] da, mc, int off);
    return (cv ? mc : da) + 16'(off);
  endfunction

  // ==========================================================================
  // driver side: note the answer, then hand the request to the master
  task automatic q(input logic [7:0] fc, input logic [15:0] a, wv,
    input logic [7:0] c, input logic [15:0] d, m);
    notes.push_back({1'b1, c != fc, c, d, m});
    u_dosm_master.send({fc, a, cv, wv}, $unsigned($random(seed)) % 2);
  endtask
  task automatic rd(input logic [7:0] fc, input logic [15:0] a, d, m);
    q(fc, a, 16'h0000, fc, d, m);
  endtask
  // one pulse of comm_ok_i when ok is set, else of comm_fail_i
  task automatic pulse(input bit ok);
    @(posedge clk_i);
    if (ok) begin
      comm_ok_i <= 1'b1;
    end else begin
      comm_fail_i <= 1'b1;
    end
    @(posedge clk_i);
    comm_ok_i <= 1'b0;
    comm_fail_i <= 1'b0;
  endtask
  task automatic end_sim();
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // monitor side: oldest note against each answer
  always @(posedge clk_i) begin
    if (rsp_o.valid === 1'b1) begin
      if (notes.size() == 0) begin
        `CHK("stray answer", 1'b0, 1'b1)
      end else begin
        nt = notes.pop_front();
        `CHK("exc", nt.r.exc, rsp_o.exc)
        `CHK("code", nt.r.code, rsp_o.code)
        `CHK("data", nt.r.data, rsp_o.data & nt.m)
      end
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #100us;
    miscompares++;
    end_sim();
  end

  initial begin
    seed = 32'h98f28845;
    {rst_i, comm_fail_i, comm_ok_i, lfd_enable_i} = 4'h8;
    {subst_value_i, line_fault_i, ow, cv, wdo} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(dosm_pkg::FC_RD_HOLD, dosm_pkg::HR_OUT_DA, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      w = $random(seed);
      cv = i[0];
      subst_value_i <= $random(seed);
      line_fault_i <= $random(seed);
      lfd_enable_i <= i[1];
      q(i[2] ? dosm_pkg::FC_WR_REGS : dosm_pkg::FC_WR_REG,
        ad(dosm_pkg::HR_OUT_DA, dosm_pkg::HR_OUT_MC, 0), w,
        i[2] ? dosm_pkg::FC_WR_REGS : dosm_pkg::FC_WR_REG, w,
        16'hFFFF);
      ow = w;
      repeat (3) @(posedge clk_i);
      #1 `CHK("ch_out", chm(), ch_out_o)
      cv = ~cv;
      k = $unsigned($random(seed)) % 16;
      w = rbm();
      st = stm();
      rd(dosm_pkg::FC_RD_HOLD, ad(dosm_pkg::HR_OUT_DA, dosm_pkg::HR_OUT_MC, 0),
        ow, 16'hFFFF);
      rd(dosm_pkg::FC_RD_HOLD, ad(dosm_pkg::HR_IN_DA, dosm_pkg::HR_IN_MC, 0),
        rbm(), 16'hFFFF);
      rd(dosm_pkg::FC_RD_DISC, ad(dosm_pkg::DI_ALLOC_DA, dosm_pkg::DI_ALLOC_MC,
        k), {15'h0, w[k]}, 16'h0001);
      rd(dosm_pkg::FC_RD_DISC, ad(dosm_pkg::DI_SLOT_DA, dosm_pkg::DI_SLOT_MC,
        8 * SLOT + k), {15'h0, w[k]}, 16'h0001);
      rd(dosm_pkg::FC_RD_INREG, ad(dosm_pkg::IR_STAT_DA, dosm_pkg::IR_STAT_MC,
        SLOT), stm(), 16'hFFFF);
      rd(dosm_pkg::FC_RD_DISC, ad(dosm_pkg::ST_BIT_DA, dosm_pkg::ST_BIT_MC,
        8 * SLOT + k % 8), {15'h0, st[8 + k % 8]}, 16'h0001);
    end
    for (int j = 0; j < 16; j++) begin
      b = $random(seed);
      cv = j[0];
      // area by bit 2, code by bit 1; read back through the other area
      w = j[2] ? ad(dosm_pkg::CO_SLOT_DA, dosm_pkg::CO_SLOT_MC, 8 * SLOT + j)
        : ad(dosm_pkg::CO_ALLOC_DA, dosm_pkg::CO_ALLOC_MC, j);
      if (j[1]) begin
        q(dosm_pkg::FC_WR_COIL, w, {b, 7'h0, 8'h00} | {8{b}} << 8,
          dosm_pkg::FC_WR_COIL, b ? 16'hFF00 : 16'h0000, 16'hFFFF);
      end else begin
        q(dosm_pkg::FC_WR_COILS, w, {15'h0, b}, dosm_pkg::FC_WR_COILS,
          {15'h0, b}, 16'hFFFF);
      end
      ow[j] = b;
      w = j[2] ? ad(dosm_pkg::CO_ALLOC_DA, dosm_pkg::CO_ALLOC_MC, j)
        : ad(dosm_pkg::CO_SLOT_DA, dosm_pkg::CO_SLOT_MC, 8 * SLOT + j);
      rd(dosm_pkg::FC_RD_COILS, w, {15'h0, b}, 16'h0001);
    end
    rd(dosm_pkg::FC_RD_INREG, ad(dosm_pkg::IR_KIND_DA, dosm_pkg::IR_KIND_MC,
      SLOT), KIND, 16'hFFFF);
    cv = 1'b0;
    q(8'h07, 16'h0000, 16'h0000, dosm_pkg::EXC_FUNC, 16'h0, 16'h0);
    q(dosm_pkg::FC_RD_HOLD, 16'h0600, 16'h0, dosm_pkg::EXC_ADDR, 16'h0,
      16'h0);
    q(dosm_pkg::FC_WR_COIL, 16'h0000, 16'h1234, dosm_pkg::EXC_VALUE, 16'h0,
      16'h0);
    rd(dosm_pkg::FC_RD_HOLD, dosm_pkg::HR_OUT_DA, ow, 16'hFFFF);
    pulse(1'b0);
    pulse(1'b0);
    pulse(1'b1);
    pulse(1'b0);
    repeat (WD + 5) @(posedge clk_i);
    #1 `CHK("wd_off early", 1'b0, wd_off_o)
    // clear the count left by the single failure, then a fresh run of three
    pulse(1'b1);
    repeat (3) pulse(1'b0);
    n = 0;
    #1;
    while (wd_off_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      #1 n++;
    end
    `CHK("wd delay", 1'b1, n >= WD - 1 && n <= WD + 2)
    wdo = 1'b1;
    @(posedge clk_i);
    #1 `CHK("ch_out off", 8'h00, ch_out_o)
    rd(dosm_pkg::FC_RD_INREG, dosm_pkg::IR_STAT_DA + 16'(SLOT), stm(),
      16'hFFFF);
    pulse(1'b1);
    wdo = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 `CHK("ch_out back", chm(), ch_out_o)
    repeat (5) @(posedge clk_i);
    `CHK("pending", 0, notes.size())
    end_sim();
  end
endmodule // tb
